// ===== src/psf_unit.sv
// Predicate, condition flag and fault status datapath behind an APB slave
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "psf_params.svh"

// Behaviour
// RQ1: Governing predicate chosen from P0-P7 only
// RQ2: Only active elements take part
// RQ3: Zeroing writes zero to inactive elements
// RQ4: Merging keeps inactive elements unchanged
// RQ5: Predicate bit per byte, sized elements
// RQ6: Fault status init sets all true
// RQ7: Failed load clears element and above
// RQ8: Loads never set fault status true
// RQ9: Only dedicated ops touch fault status
// RQ10: Fault status accesses in program order
// RQ11: Narrow scalar results are zero-extended
// RQ12: N is first active element true
// RQ13: Z set when no active true
// RQ14: C clear when last active true
// RQ15: V cleared except compare-terminate ops
// RQ16: Governing predicate limits tested elements
// RQ17: Unpredicated means all elements active
// RQ18: More and final-or-none condition aliases
// RQ19: Continue and halt aliases from N, V
// RQ20: Element true when lowest bit set
// RQ21: First active is lowest active
// RQ22: Last active is highest active
// RQ23: No active gives N0 Z1 C1
module psf_unit #(
	parameter int VBYTES = 4,
	parameter int AW     = 12
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [AW-1:0] paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr
);
	localparam int PB = VBYTES;
	localparam int VW = VBYTES * 8;
	localparam logic [1:0] ES_MAX = 2'($clog2(VBYTES));

	logic [PB-1:0]          pred_r [8];
	logic [PB-1:0]          fault_stat_r;
	logic [VW-1:0]          vsrc_r;
	logic [VW-1:0]          vdst_r;
	logic [31:0]            sca_r;
	logic [31:0]            scb_r;
	logic [31:0]            res_r;
	logic [31:0]            ctrl_r;
	psf_pkg::psf_flags_type flags_r;
	logic [31:0]            prdata_r;
	logic                   pready_r;
	logic                   pslverr_r;

	psf_pkg::psf_ctrl_type  c;
	logic                   wr;
	logic                   go;
	logic [1:0]             es;
	logic [PB-1:0]          lead;
	logic [PB-1:0]          gov;
	logic [PB-1:0]          act;
	logic [PB-1:0]          am;
	logic                   pd_we;
	logic [PB-1:0]          pd_nxt;
	logic                   vd_we;
	logic [VW-1:0]          vd_nxt;
	logic                   fault_stat_we;
	logic [PB-1:0]          fault_stat_nxt;
	logic                   fl_we;
	psf_pkg::psf_flags_type fl_nxt;
	logic                   res_we;
	logic [31:0]            res_nxt;

	// Lowest bit of each element, the only bit that decides truth
	function automatic logic [PB-1:0] lead_bits(input logic [1:0] e);
		for (int b = 0; b < PB; b++)
			lead_bits[b] = (b % (1 << e)) == 0;
	endfunction : lead_bits

	// Copies each element's lowest bit over all bytes of that element
	function automatic logic [PB-1:0] spread(input logic [PB-1:0] p, input logic [1:0] e);
		for (int b = 0; b < PB; b++)
			spread[b] = p[b - (b % (1 << e))];
	endfunction : spread

	function automatic logic [VW-1:0] bitmask(input logic [PB-1:0] m);
		for (int b = 0; b < PB; b++)
			bitmask[b*8 +: 8] = {8{m[b]}};
	endfunction : bitmask

	function automatic psf_pkg::psf_flags_type pflags(input logic [PB-1:0] a,
			input logic [PB-1:0] r);
		psf_pkg::psf_flags_type f;
		f = '{n: 1'b0, z: 1'b1, c: 1'b1, v: 1'b0}; // [RQ23] [RQ15]
		for (int b = PB - 1; b >= 0; b--)
			if (a[b])
				f.n = r[b]; // [RQ12] [RQ21]
		for (int b = 0; b < PB; b++)
			if (a[b])
				f.c = !r[b]; // [RQ14] [RQ22]
		f.z = (a & r) == '0; // [RQ13] [RQ16]
		return f;
	endfunction : pflags

	function automatic logic [7:0] count_true(input logic [PB-1:0] p);
		logic [7:0] n;
		n = 8'h00;
		for (int b = 0; b < PB; b++)
			n = n + 8'(p[b]);
		return n;
	endfunction : count_true

	assign wr = psel && penable && pready_r && pwrite;
	// Ops execute one per bus write, so every access is in program order [RQ10]
	assign go = wr && (paddr == `PSF_OFF_CTRL);
	// One process fills the whole control word, so it has a single driver
	always_comb
	begin
		c.op = psf_pkg::psf_op_type'(pwdata[`PSF_POS_OP +: 4]);
		c.gov = pwdata[`PSF_POS_GOV +: 3]; // [RQ1]
		c.pen = pwdata[`PSF_POS_PEN];
		c.zero = pwdata[`PSF_POS_ZERO];
		c.es = pwdata[`PSF_POS_ES +: 2];
		c.fset = pwdata[`PSF_POS_FSET];
		c.pdst = pwdata[`PSF_POS_PDST +: 3];
		c.psrc = pwdata[`PSF_POS_PSRC +: 3];
		c.psrc2 = pwdata[`PSF_POS_PSRC2 +: 3];
		c.idx = pwdata[`PSF_POS_IDX +: 5];
		c.endp = pwdata[`PSF_POS_END];
	end

	assign es = (c.es > ES_MAX) ? ES_MAX : c.es; // [RQ5]
	assign lead = lead_bits(es);
	assign gov = c.pen ? pred_r[c.gov] : '1; // [RQ17]
	assign act = gov & lead; // [RQ20] [RQ2]
	assign am = spread(act, es);

	always_comb
	begin
		logic [PB-1:0] r;
		logic          t;
		r = '0;
		t = 1'b0;
		pd_we = 1'b0;
		pd_nxt = pred_r[c.pdst];
		vd_we = 1'b0;
		vd_nxt = vdst_r;
		fault_stat_we = 1'b0;
		fault_stat_nxt = fault_stat_r;
		fl_we = 1'b0;
		fl_nxt = flags_r;
		res_we = 1'b0;
		res_nxt = res_r;
		unique case (c.op)
			psf_pkg::PSF_OP_VSEL:
			begin
				vd_we = 1'b1;
				vd_nxt = (vsrc_r & bitmask(am)) // [RQ2]
					| (c.zero ? '0 : (vdst_r & ~bitmask(am))); // [RQ3] [RQ4]
			end
			psf_pkg::PSF_OP_PAND:
			begin
				r = pred_r[c.psrc] & pred_r[c.psrc2] & act;
				pd_we = 1'b1;
				pd_nxt = r | (c.zero ? '0 : (pred_r[c.pdst] & ~am)); // [RQ3] [RQ4]
				fl_we = c.fset;
				fl_nxt = pflags(act, r);
			end
			psf_pkg::PSF_OP_PTEST:
			begin
				fl_we = 1'b1;
				fl_nxt = pflags(act, pred_r[c.psrc] & lead); // [RQ16]
			end
			psf_pkg::PSF_OP_FS_INIT:
			begin
				fault_stat_we = 1'b1;
				fault_stat_nxt = '1; // [RQ6]
			end
			psf_pkg::PSF_OP_FS_READ, psf_pkg::PSF_OP_FS_READF:
			begin
				pd_we = 1'b1;
				pd_nxt = fault_stat_r & am; // [RQ9]
				fl_we = c.op == psf_pkg::PSF_OP_FS_READF;
				fl_nxt = pflags(act, fault_stat_r & lead);
			end
			psf_pkg::PSF_OP_FS_WRITE:
			begin
				fault_stat_we = 1'b1;
				fault_stat_nxt = pred_r[c.psrc]; // [RQ9]
			end
			psf_pkg::PSF_OP_LOAD_FAIL:
			begin
				// Only ever clears, so faults pile up until the next init or fault status write
				fault_stat_we = 1'b1;
				for (int b = 0; b < PB; b++)
					if (b >= (int'(c.idx) << es))
						fault_stat_nxt[b] = 1'b0; // [RQ7] [RQ8]
			end
			psf_pkg::PSF_OP_CTERM_EQ, psf_pkg::PSF_OP_CTERM_NE:
			begin
				t = (sca_r == scb_r) ^ (c.op == psf_pkg::PSF_OP_CTERM_NE);
				fl_we = 1'b1;
				fl_nxt.n = t;
				fl_nxt.v = !t && c.endp; // [RQ15]
			end
			psf_pkg::PSF_OP_COUNT:
			begin
				res_we = 1'b1;
				res_nxt = {24'h00_0000, count_true(pred_r[c.psrc] & act)}; // [RQ11]
			end
			default:
			begin
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			for (int i = 0; i < 8; i++)
				pred_r[i] <= '0;
		else if (go && pd_we)
			pred_r[c.pdst] <= pd_nxt;
		else if (wr && ((paddr & `PSF_PRED_MASK) == `PSF_OFF_PRED))
			pred_r[paddr[4:2]] <= pwdata[PB-1:0];
	end

	// Fault status has no bus address; only the dedicated ops reach it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fault_stat_r <= '1;
		else if (go && fault_stat_we)
			fault_stat_r <= fault_stat_nxt; // [RQ9]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			vsrc_r <= '0;
			vdst_r <= '0;
			sca_r <= `PSF_RST_WORD;
			scb_r <= `PSF_RST_WORD;
			ctrl_r <= `PSF_RST_WORD;
		end
		else if (wr)
		begin
			if (paddr == `PSF_OFF_VSRC)
				vsrc_r <= pwdata[VW-1:0];
			if (paddr == `PSF_OFF_VDST)
				vdst_r <= pwdata[VW-1:0];
			else if (go && vd_we)
				vdst_r <= vd_nxt;
			if (paddr == `PSF_OFF_SCA)
				sca_r <= pwdata;
			if (paddr == `PSF_OFF_SCB)
				scb_r <= pwdata;
			if (go)
				ctrl_r <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flags_r <= `PSF_RST_FLAGS;
			res_r <= `PSF_RST_WORD;
		end
		else if (go)
		begin
			if (fl_we)
				flags_r <= fl_nxt;
			if (res_we)
				res_r <= res_nxt;
		end
	end

	// Read data is latched in the setup phase so the access phase needs no wait
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r <= `PSF_RST_WORD;
			pslverr_r <= 1'b0;
			pready_r <= 1'b0;
		end
		else
		begin
			pready_r <= 1'b1;
			if (psel && !penable)
			begin
				pslverr_r <= 1'b0;
				prdata_r <= '0;
				if ((paddr & `PSF_PRED_MASK) == `PSF_OFF_PRED)
					prdata_r <= 32'(pred_r[paddr[4:2]]);
				else
					unique case (paddr)
						`PSF_OFF_CTRL:   prdata_r <= ctrl_r;
						`PSF_OFF_FLAGS:  prdata_r <= {22'h0, flags_r.c & !flags_r.z, // [RQ18]
							!flags_r.c | flags_r.z, flags_r.n == flags_r.v, // [RQ19]
							flags_r.n != flags_r.v, flags_r.c, !flags_r.n, flags_r};
						`PSF_OFF_VSRC:   prdata_r <= 32'(vsrc_r);
						`PSF_OFF_VDST:   prdata_r <= 32'(vdst_r);
						`PSF_OFF_SCA:    prdata_r <= sca_r;
						`PSF_OFF_SCB:    prdata_r <= scb_r;
						`PSF_OFF_RESULT: prdata_r <= res_r;
						default:         pslverr_r <= 1'b1;
					endcase
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	chk_fault_init: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
		go && c.op == psf_pkg::PSF_OP_FS_INIT |=> fault_stat_r == '1)
		else $error("fault status not all true after init");
	chk_fault_no_set: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
		go && c.op == psf_pkg::PSF_OP_LOAD_FAIL
		|=> (fault_stat_r & ~$past(fault_stat_r)) == '0)
		else $error("load set a fault status bit");
	chk_fault_run: assert property (@(posedge pclk) disable iff (!presetn) // [RQ7]
		go && c.op == psf_pkg::PSF_OP_LOAD_FAIL && c.idx == 5'h00 |=> fault_stat_r == '0)
		else $error("fail at element zero left true bits");
	chk_vsel_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
		go && c.op == psf_pkg::PSF_OP_VSEL && c.zero
		|=> (vdst_r & ~bitmask($past(am))) == '0)
		else $error("inactive byte not zeroed");
	chk_vsel_merge: assert property (@(posedge pclk) disable iff (!presetn) // [RQ4]
		go && c.op == psf_pkg::PSF_OP_VSEL && !c.zero
		|=> ((vdst_r ^ $past(vdst_r)) & ~bitmask($past(am))) == '0)
		else $error("inactive byte changed under merging");
	chk_none_active: assert property (@(posedge pclk) disable iff (!presetn) // [RQ23]
		go && c.op == psf_pkg::PSF_OP_PTEST && act == '0
		|=> flags_r == 4'h6)
		else $error("flags wrong with no active element");
	chk_v_cleared: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
		go && c.op == psf_pkg::PSF_OP_PTEST |=> !flags_r.v)
		else $error("overflow not cleared by test");
	chk_zero_flag: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
		go && c.op == psf_pkg::PSF_OP_PTEST |=> flags_r.z == $past((pred_r[c.psrc] & act) == '0))
		else $error("zero flag disagrees with active bits");
	chk_count_ext: assert property (@(posedge pclk) disable iff (!presetn) // [RQ11]
		go && c.op == psf_pkg::PSF_OP_COUNT |=> res_r[31:8] == 24'h00_0000)
		else $error("narrow result not zero extended");
	chk_cterm_alias: assert property (@(posedge pclk) disable iff (!presetn) // [RQ19]
		go && c.op == psf_pkg::PSF_OP_CTERM_EQ && sca_r == scb_r
		|=> flags_r.n != flags_r.v)
		else $error("equal compare did not halt");
	chk_unpred_all: assert property (@(posedge pclk) disable iff (!presetn) // [RQ17]
		go && c.op == psf_pkg::PSF_OP_PTEST && !c.pen && es == 2'h0 && pred_r[c.psrc] == '1
		|=> flags_r == 4'h8)
		else $error("unpredicated test missed an element");
	chk_carry_last: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14]
		go && c.op == psf_pkg::PSF_OP_PTEST && act != '0 && (pred_r[c.psrc] & act) == act
		|=> !flags_r.c)
		else $error("carry set although last active true");
	chk_neg_first: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
		go && c.op == psf_pkg::PSF_OP_PTEST && act != '0 && (pred_r[c.psrc] & act) == act
		|=> flags_r.n)
		else $error("negative clear although first active true");
	chk_load_keep: assert property (@(posedge pclk) disable iff (!presetn) // [RQ7]
		go && c.op == psf_pkg::PSF_OP_LOAD_FAIL && c.idx == 5'h01 && es == 2'h0
		|=> fault_stat_r[0] == $past(fault_stat_r[0]))
		else $error("load fail touched a lower element");
endmodule : psf_unit
`default_nettype wire

// ===== src/psf_params.svh
// Register offsets, control field positions and reset values of the predicate flag unit
`ifndef PSF_PARAMS_SVH
`define PSF_PARAMS_SVH
`define PSF_OFF_CTRL    12'h000
`define PSF_OFF_FLAGS   12'h004
`define PSF_OFF_VSRC    12'h008
`define PSF_OFF_VDST    12'h00C
`define PSF_OFF_SCA     12'h010
`define PSF_OFF_SCB     12'h014
`define PSF_OFF_RESULT  12'h018
`define PSF_OFF_PRED    12'h020
`define PSF_PRED_MASK   12'hFE0
`define PSF_POS_OP      0
`define PSF_POS_GOV     4
`define PSF_POS_PEN     7
`define PSF_POS_ZERO    8
`define PSF_POS_ES      9
`define PSF_POS_FSET    11
`define PSF_POS_PDST    12
`define PSF_POS_PSRC    15
`define PSF_POS_PSRC2   18
`define PSF_POS_IDX     21
`define PSF_POS_END     26
`define PSF_RST_WORD    32'h0000_0000
`define PSF_RST_FLAGS   4'h0
`endif

// ===== src/psf_pkg.sv
// Types shared by the predicate flag unit
package psf_pkg;
	typedef enum logic [3:0] {
		PSF_OP_NOP       = 4'h0,
		PSF_OP_VSEL      = 4'h1,
		PSF_OP_PAND      = 4'h2,
		PSF_OP_PTEST     = 4'h3,
		PSF_OP_FS_INIT   = 4'h4,
		PSF_OP_FS_READ   = 4'h5,
		PSF_OP_FS_READF  = 4'h6,
		PSF_OP_FS_WRITE  = 4'h7,
		PSF_OP_LOAD_FAIL = 4'h8,
		PSF_OP_CTERM_EQ  = 4'h9,
		PSF_OP_CTERM_NE  = 4'hA,
		PSF_OP_COUNT     = 4'hB
	} psf_op_type;
	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} psf_flags_type;
	typedef struct packed {
		psf_op_type op;
		logic [2:0] gov;
		logic       pen;
		logic       zero;
		logic [1:0] es;
		logic       fset;
		logic [2:0] pdst;
		logic [2:0] psrc;
		logic [2:0] psrc2;
		logic [4:0] idx;
		logic       endp;
	} psf_ctrl_type;
endpackage : psf_pkg

// ===== sim/psf_pipe_model.sv
// APB master standing in for the instruction pipeline
`timescale 1ns/1ps
`default_nettype none
module psf_pipe_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end
	// Request held until pready is seen high at a rising edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench watchdog ends a wait that never sees pready
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released data must not keep showing the last value
		pwdata <= ~d;
	endtask : xfer
endmodule : psf_pipe_model
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the predicate flag unit
`timescale 1ns/1ps
`default_nettype none
`include "psf_params.svh"
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	int          errors = 0;
	int          num_checks = 0;
	localparam logic [11:0] FL = `PSF_OFF_FLAGS;
	localparam logic [11:0] VD = `PSF_OFF_VDST;
	psf_unit #(.VBYTES(4), .AW(12)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	psf_pipe_model m (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	function automatic logic [11:0] pa(input int n);
		return 12'(`PSF_OFF_PRED + 4 * n);
	endfunction : pa
	function automatic logic [31:0] fl(input logic n, z, c, v);
		return {22'h0, c & !z, !c | z, n == v, n != v, c, !n, n, z, c, v};
	endfunction : fl
	// Flag setting is always requested; ops without flags ignore it
	function automatic logic [31:0] cw(input int op, g, pen, z, es, ps, pd = 0,
		p2 = 0, ix = 0, e = 0);
		return 32'(op | g << `PSF_POS_GOV | pen << `PSF_POS_PEN | z << `PSF_POS_ZERO
			| es << `PSF_POS_ES | 1 << `PSF_POS_FSET | pd << `PSF_POS_PDST
			| ps << `PSF_POS_PSRC | p2 << `PSF_POS_PSRC2 | ix << `PSF_POS_IDX
			| e << `PSF_POS_END);
	endfunction : cw
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		m.xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		m.xfer(1'b0, a, 32'h0, q, e);
		chk(nm, exp, q);
		chk("slverr", 32'h0, {31'h0, e});
	endtask : rd
	task automatic ex(input logic [31:0] w);
		wr(`PSF_OFF_CTRL, w);
	endtask : ex
	task automatic tst(input int g, pen, es, ps, input logic [31:0] exp);
		ex(cw(3, g, pen, 0, es, ps));
		rd("flags", FL, exp);
	endtask : tst
	task automatic vs(input int z, es, input logic [31:0] exp);
		wr(VD, 32'hAABB_CCDD);
		ex(cw(1, 2, 1, z, es, 0));
		rd("vdst", VD, exp);
	endtask : vs
	task automatic fs(input logic [31:0] exp);
		ex(cw(5, 0, 0, 0, 0, 0, 5));
		rd("fault", pa(5), exp);
	endtask : fs
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	initial
	begin
		repeat (20000) @(posedge pclk);
		errors++;
		$display("watchdog expired");
		end_of_test();
	end
	initial
	begin
		logic [31:0] q;
		logic        e;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd("pred0", pa(0), 32'h0);
		rd("flags", FL, fl(0, 0, 0, 0));
		wr(FL, 32'hFFFF_FFFF);
		rd("flags", FL, fl(0, 0, 0, 0));
		m.xfer(1'b0, 12'h01C, 32'h0, q, e);
		chk("unmapped", 32'h0, q);
		chk("slverr", 32'h1, {31'h0, e});
		$display("test bus done");
		wr(pa(1), 32'hF);
		wr(pa(2), 32'h5);
		wr(pa(4), 32'hA);
		ex(cw(2, 0, 0, 0, 0, 1, 3, 2));
		rd("pand", pa(3), 32'h5);
		rd("flags", FL, fl(1, 0, 1, 0));
		ex(cw(2, 0, 0, 0, 0, 1, 3, 4));
		rd("flags", FL, fl(0, 0, 0, 0));
		tst(2, 1, 0, 4, fl(0, 1, 1, 0));
		tst(0, 1, 0, 1, fl(0, 1, 1, 0));
		tst(2, 1, 0, 1, fl(1, 0, 0, 0));
		tst(4, 1, 0, 4, fl(1, 0, 0, 0));
		tst(7, 1, 0, 1, fl(0, 1, 1, 0));
		tst(0, 0, 1, 4, fl(0, 1, 1, 0));
		$display("test flags done");
		wr(`PSF_OFF_SCA, 32'h7);
		wr(`PSF_OFF_SCB, 32'h7);
		rd("sca", `PSF_OFF_SCA, 32'h7);
		rd("scb", `PSF_OFF_SCB, 32'h7);
		ex(cw(10, 0, 0, 0, 0, 0, 0, 0, 0, 1));
		rd("flags", FL, fl(0, 1, 1, 1));
		ex(cw(9, 0, 0, 0, 0, 0, 0, 0, 0, 1));
		rd("flags", FL, fl(1, 1, 1, 0));
		ex(cw(10, 0, 0, 0, 0, 0, 0, 0, 0, 1));
		tst(0, 0, 0, 1, fl(1, 0, 0, 0));
		$display("test terminate done");
		wr(`PSF_OFF_VSRC, 32'h1122_3344);
		rd("vsrc", `PSF_OFF_VSRC, 32'h1122_3344);
		vs(0, 0, 32'hAA22_CC44);
		vs(1, 0, 32'h0022_0044);
		vs(1, 1, 32'h1122_3344);
		ex(cw(11, 4, 1, 0, 0, 1));
		wr(`PSF_OFF_RESULT, 32'hFFFF_FFFF);
		rd("result", `PSF_OFF_RESULT, 32'h2);
		$display("test vector done");
		ex(cw(4, 0, 0, 0, 0, 0));
		fs(32'hF);
		ex(cw(8, 0, 0, 0, 0, 0, 0, 0, 2));
		fs(32'h3);
		ex(cw(8, 0, 0, 0, 0, 0, 0, 0, 3));
		fs(32'h3);
		ex(cw(8, 0, 0, 0, 0, 0, 0, 0, 1));
		ex(cw(6, 0, 0, 0, 0, 0, 6));
		rd("fault", pa(6), 32'h1);
		rd("flags", FL, fl(1, 0, 1, 0));
		ex(cw(7, 0, 0, 0, 0, 4));
		fs(32'hA);
		rd("ctrl", `PSF_OFF_CTRL, cw(5, 0, 0, 0, 0, 0, 5));
		ex(cw(8, 0, 0, 0, 0, 0, 0, 0, 3));
		fs(32'h2);
		ex(cw(4, 0, 0, 0, 0, 0));
		fs(32'hF);
		$display("test fault done");
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
